// File: shared/spec_defer_pkg.sv
package spec_defer_pkg;

    localparam int NUM_FLAGS = 7;
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 32;
    localparam int CLASS_W   = 3;
    localparam int CAUSE_W   = 4;
    localparam int NUM_IRQ   = 2;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_DCR      = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_FSR      = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_SAVED    = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_CFG      = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_IRQ_CLR  = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_IRQ_EN   = 8'h18;

    // Reset values
    localparam logic [NUM_FLAGS-1:0] DCR_RESET   = 7'h00;
    localparam logic                 CFG_RESET   = 1'b1;
    localparam logic [NUM_IRQ-1:0]   IRQ_EN_RESET = 2'h0;

    // Field positions
    localparam int FSR_SP_BIT     = 0;
    localparam int FSR_ED_BIT     = 1;
    localparam int FSR_CAUSE_LSB  = 4;
    localparam int SAVED_REQ_BIT  = 0;
    localparam int CFG_UNALIGN_BIT = 0;
    localparam int IRQ_DELIVER_BIT = 0;
    localparam int IRQ_DEFER_BIT   = 1;

    // Fault class codes; code N selects deferral flag N-1
    localparam logic [CLASS_W-1:0] CLASS_NONE = 3'h0;

    // Cause codes reported on delivery
    localparam logic [CAUSE_W-1:0] CAUSE_NONE      = 4'h0;
    localparam logic [CAUSE_W-1:0] CAUSE_UNALIGNED = 4'h8;

    typedef enum logic [1:0] {
        OUT_IDLE    = 2'b00,
        OUT_DONE    = 2'b01,
        OUT_DEFER   = 2'b10,
        OUT_DELIVER = 2'b11
    } outcome_e;

endpackage

// File: hw/defer_select.sv
`timescale 1ns/1ps
`default_nettype none

module defer_select
    import spec_defer_pkg::*;
#(
    parameter int N = NUM_FLAGS
) (
    input  wire logic [CLASS_W-1:0] class_code,
    input  wire logic [N-1:0]       flags,
    output logic                    flag_sel
);

    logic [N-1:0] hit;

    // Exactly one flag governs a class
    for (genvar i = 0; i < N; i++) begin : g_sel
        assign hit[i] = (class_code == CLASS_W'(i + 1)) && flags[i];
    end

    assign flag_sel = |hit;

endmodule

`default_nettype wire

// File: hw/irq_sticky.sv
`timescale 1ns/1ps
`default_nettype none

module irq_sticky
    import spec_defer_pkg::*;
#(
    parameter int N = NUM_IRQ
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         ce,
    input  wire logic [N-1:0] set,
    input  wire logic         clr_wr,
    input  wire logic [N-1:0] clr_mask,
    input  wire logic [N-1:0] enable,
    output logic [N-1:0]      status_q,
    output logic              irq
);

    for (genvar i = 0; i < N; i++) begin : g_bit
        logic status_d;
        // Set wins over a clear in the same cycle
        assign status_d = set[i] | (status_q[i] & ~(clr_wr & clr_mask[i]));
        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                status_q[i] <= 1'b0;
            end else if (ce) begin
                status_q[i] <= status_d;
            end
        end
    end

    assign irq = |(status_q & enable);

endmodule

`default_nettype wire

// File: hw/spec_load_fault_deferral.sv
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module spec_load_fault_deferral
    import spec_defer_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               sys_rst,
    input  wire logic               ce,
    input  wire logic [ADDR_W-1:0]  reg_addr,
    input  wire logic [DATA_W-1:0]  reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic [DATA_W-1:0]       reg_rdata,
    input  wire logic               ld_valid,
    input  wire logic               ld_cspec,
    input  wire logic [CLASS_W-1:0] ld_fault_class,
    input  wire logic               ld_misaligned,
    input  wire logic               ld_fp_target,
    input  wire logic               page_recovery_bit,
    output logic                    ld_done,
    output logic                    result_defer,
    output logic                    deferred_token_bit,
    output logic                    deferred_float_value,
    output logic                    fault_deliver,
    output logic [CAUSE_W-1:0]      fault_cause,
    output logic                    irq
);

    // Software visible state
    logic [NUM_FLAGS-1:0] default_control_reg_q;
    logic                 speculative_fault_flag_q;
    logic                 fault_recovery_flag_q;
    logic [CAUSE_W-1:0]   fsr_cause_q;
    logic                 saved_defer_request_q;
    logic                 saved_defer_request_d;
    logic                 cfg_unalign_q;
    logic [NUM_IRQ-1:0]   irq_en_q;
    logic [NUM_IRQ-1:0]   irq_status;
    logic [DATA_W-1:0]    reg_rdata_q;

    // Result state
    outcome_e             outcome_q;
    outcome_e             outcome_d;
    logic                 token_q;
    logic                 float_q;
    logic [CAUSE_W-1:0]   cause_q;

    // Bus decode
    wire wr_en    = reg_wr & ce;
    wire wr_dcr   = wr_en & (reg_addr == OFF_DCR);
    wire wr_saved = wr_en & (reg_addr == OFF_SAVED);
    wire wr_cfg   = wr_en & (reg_addr == OFF_CFG);
    wire wr_clr   = wr_en & (reg_addr == OFF_IRQ_CLR);
    wire wr_ien   = wr_en & (reg_addr == OFF_IRQ_EN);

    // Fault decision
    logic flag_sel;

    defer_select #(
        .N (NUM_FLAGS)
    ) u_select (
        .class_code (ld_fault_class),
        .flags      (default_control_reg_q),
        .flag_sel   (flag_sel)
    );

    wire has_fault    = (ld_fault_class != CLASS_NONE);
    wire unalign_hit  = ld_misaligned & cfg_unalign_q;
    wire excepting    = has_fault | unalign_hit;
    wire hw_defer     = ld_cspec & has_fault & flag_sel;
    wire sw_defer     = ld_cspec & excepting & saved_defer_request_q;
    wire defer_now    = ld_valid & (hw_defer | sw_defer);
    wire deliver_now  = ld_valid & excepting & ~(hw_defer | sw_defer);
    wire done_now     = ld_valid & ~excepting;
    wire [CAUSE_W-1:0] cause_now = has_fault ? {1'b0, ld_fault_class}
                                             : CAUSE_UNALIGNED;
    wire consume_req  = ld_valid & ld_cspec & excepting;

    // Outcome chosen before any result is written
    always_comb begin
        if (defer_now) begin
            outcome_d = OUT_DEFER;
        end else if (deliver_now) begin
            outcome_d = OUT_DELIVER;
        end else if (done_now) begin
            outcome_d = OUT_DONE;
        end else begin
            outcome_d = OUT_IDLE;
        end
    end

    // Software write of the saved request wins over consumption
    always_comb begin
        if (wr_saved) begin
            saved_defer_request_d = reg_wdata[SAVED_REQ_BIT];
        end else if (consume_req) begin
            saved_defer_request_d = 1'b0;
        end else begin
            saved_defer_request_d = saved_defer_request_q;
        end
    end

    // Control registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            default_control_reg_q <= DCR_RESET;
            cfg_unalign_q         <= CFG_RESET;
            irq_en_q              <= IRQ_EN_RESET;
        end else begin
            if (wr_dcr) begin
                default_control_reg_q <= reg_wdata[NUM_FLAGS-1:0];
            end
            if (wr_cfg) begin
                cfg_unalign_q <= reg_wdata[CFG_UNALIGN_BIT];
            end
            if (wr_ien) begin
                irq_en_q <= reg_wdata[NUM_IRQ-1:0];
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            saved_defer_request_q <= 1'b0;
        end else if (ce) begin
            saved_defer_request_q <= saved_defer_request_d;
        end
    end

    // Fault status, updated on delivery only
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            speculative_fault_flag_q <= 1'b0;
            fault_recovery_flag_q    <= 1'b0;
            fsr_cause_q              <= CAUSE_NONE;
        end else if (ce && deliver_now) begin
            speculative_fault_flag_q <= ld_cspec;
            fault_recovery_flag_q    <= ld_cspec & page_recovery_bit;
            fsr_cause_q              <= cause_now;
        end
    end

    // Result stage
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            outcome_q <= OUT_IDLE;
            token_q   <= 1'b0;
            float_q   <= 1'b0;
            cause_q   <= CAUSE_NONE;
        end else if (ce) begin
            outcome_q <= outcome_d;
            token_q   <= defer_now & ~ld_fp_target;
            float_q   <= defer_now & ld_fp_target;
            cause_q   <= deliver_now ? cause_now : CAUSE_NONE;
        end
    end

    always_comb begin
        ld_done       = 1'b0;
        result_defer  = 1'b0;
        fault_deliver = 1'b0;
        unique case (outcome_q)
            OUT_IDLE: begin
            end
            OUT_DONE: begin
                ld_done = 1'b1;
            end
            OUT_DEFER: begin
                result_defer = 1'b1;
            end
            OUT_DELIVER: begin
                fault_deliver = 1'b1;
            end
        endcase
    end

    assign deferred_token_bit   = token_q;
    assign deferred_float_value = float_q;
    assign fault_cause          = cause_q;

    // Event status and interrupt
    irq_sticky #(
        .N (NUM_IRQ)
    ) u_irq (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .ce       (ce),
        .set      ({defer_now, deliver_now}),
        .clr_wr   (wr_clr),
        .clr_mask (reg_wdata[NUM_IRQ-1:0]),
        .enable   (irq_en_q),
        .status_q (irq_status),
        .irq      (irq)
    );

    // Read path
    logic [DATA_W-1:0] rd_word;

    always_comb begin
        rd_word = '0;
        unique case (reg_addr)
            OFF_DCR: begin
                rd_word[NUM_FLAGS-1:0] = default_control_reg_q;
            end
            OFF_FSR: begin
                rd_word[FSR_SP_BIT] = speculative_fault_flag_q;
                rd_word[FSR_ED_BIT] = fault_recovery_flag_q;
                rd_word[FSR_CAUSE_LSB +: CAUSE_W] = fsr_cause_q;
            end
            OFF_SAVED: begin
                rd_word[SAVED_REQ_BIT] = saved_defer_request_q;
            end
            OFF_CFG: begin
                rd_word[CFG_UNALIGN_BIT] = cfg_unalign_q;
            end
            OFF_IRQ_STAT: begin
                rd_word[NUM_IRQ-1:0] = irq_status;
            end
            OFF_IRQ_EN: begin
                rd_word[NUM_IRQ-1:0] = irq_en_q;
            end
            default: begin
                rd_word = '0;
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata_q <= '0;
        end else if (ce) begin
            reg_rdata_q <= reg_rd ? rd_word : '0;
        end
    end

    assign reg_rdata = reg_rdata_q;

    // Checks
    property p_defer_flag_set;
        @(posedge clk) disable iff (sys_rst)
        (ce && ld_valid && ld_cspec && has_fault && flag_sel)
            |=> (result_defer && !fault_deliver);
    endproperty
    a_defer_flag_set: assert property (p_defer_flag_set)
        else $error("deferral flag set but fault not deferred");

    property p_deliver_flag_clear;
        @(posedge clk) disable iff (sys_rst)
        (ce && ld_valid && ld_cspec && has_fault && !flag_sel && !saved_defer_request_q)
            |=> (fault_deliver && !result_defer);
    endproperty
    a_deliver_flag_clear: assert property (p_deliver_flag_clear)
        else $error("deferral flag clear but fault not delivered");

    property p_all_flags_set;
        @(posedge clk) disable iff (sys_rst)
        (ce && ld_valid && ld_cspec && has_fault && (&default_control_reg_q))
            |=> !fault_deliver;
    endproperty
    a_all_flags_set: assert property (p_all_flags_set)
        else $error("fault delivered with every deferral flag set");

    property p_all_flags_clear;
        @(posedge clk) disable iff (sys_rst)
        (ce && ld_valid && ld_cspec && has_fault && (default_control_reg_q == '0)
            && !saved_defer_request_q)
            |=> (fault_deliver && (fault_cause == {1'b0, $past(ld_fault_class)}));
    endproperty
    a_all_flags_clear: assert property (p_all_flags_clear)
        else $error("fault class not delivered with all flags clear");

    property p_spec_flag;
        @(posedge clk) disable iff (sys_rst)
        fault_deliver |-> (speculative_fault_flag_q == $past(ld_cspec));
    endproperty
    a_spec_flag: assert property (p_spec_flag)
        else $error("speculative fault flag does not match the load kind");

    property p_recovery_copy;
        @(posedge clk) disable iff (sys_rst)
        (fault_deliver && speculative_fault_flag_q)
            |-> (fault_recovery_flag_q == $past(page_recovery_bit));
    endproperty
    a_recovery_copy: assert property (p_recovery_copy)
        else $error("recovery flag not copied from page bit");

    property p_saved_request;
        @(posedge clk) disable iff (sys_rst)
        (ce && ld_valid && ld_cspec && excepting && saved_defer_request_q && !wr_saved)
            |=> (result_defer && !saved_defer_request_q);
    endproperty
    a_saved_request: assert property (p_saved_request)
        else $error("saved defer request not honoured");

    property p_token_kind;
        @(posedge clk) disable iff (sys_rst)
        result_defer |-> ((deferred_float_value == $past(ld_fp_target))
            && (deferred_token_bit == !$past(ld_fp_target)));
    endproperty
    a_token_kind: assert property (p_token_kind)
        else $error("deferred marking does not match target kind");

    property p_unaligned;
        @(posedge clk) disable iff (sys_rst)
        (ce && ld_valid && !ld_cspec && ld_misaligned && cfg_unalign_q && !has_fault)
            |=> (fault_deliver && (fault_cause == CAUSE_UNALIGNED));
    endproperty
    a_unaligned: assert property (p_unaligned)
        else $error("misaligned load did not raise unaligned fault");

    property p_no_update_on_fault;
        @(posedge clk) disable iff (sys_rst)
        (ce && ld_valid && excepting) |=> (!ld_done && (result_defer != fault_deliver));
    endproperty
    a_no_update_on_fault: assert property (p_no_update_on_fault)
        else $error("load completed although its fault was taken");

    property p_plain_never_defers;
        @(posedge clk) disable iff (sys_rst)
        (ce && ld_valid && !ld_cspec) |=> !result_defer;
    endproperty
    a_plain_never_defers: assert property (p_plain_never_defers)
        else $error("non-speculative load was deferred");

    property p_fsr_held_on_defer;
        @(posedge clk) disable iff (sys_rst)
        (ce && !deliver_now)
            |=> $stable({speculative_fault_flag_q, fault_recovery_flag_q, fsr_cause_q});
    endproperty
    a_fsr_held_on_defer: assert property (p_fsr_held_on_defer)
        else $error("fault status changed without a delivered fault");

    property p_deliver_no_token;
        @(posedge clk) disable iff (sys_rst)
        fault_deliver |-> (!deferred_token_bit && !deferred_float_value);
    endproperty
    a_deliver_no_token: assert property (p_deliver_no_token)
        else $error("delivered fault also marked a deferred token");

endmodule

`default_nettype wire

// File: verif/spec_load_fault_deferral_bench.sv
`timescale 1ns/1ps
`default_nettype none

module spec_load_fault_deferral_bench
    import spec_defer_pkg::*;
;
    localparam logic [8:0] DONE9 = 9'h100;

    logic               clk = 1'b0;
    logic               sys_rst, ce, reg_wr, reg_rd, irq;
    logic [ADDR_W-1:0]  reg_addr;
    logic [DATA_W-1:0]  reg_wdata, reg_rdata;
    logic               ld_valid, ld_cspec, ld_misaligned, ld_fp_target, page_recovery_bit;
    logic [CLASS_W-1:0] ld_fault_class;
    logic               ld_done, result_defer, deferred_token_bit, deferred_float_value;
    logic               fault_deliver;
    logic [CAUSE_W-1:0] fault_cause;
    int                 fails = 0;
    int                 compares = 0;

    always #20 clk = ~clk;

    spec_load_fault_deferral dut_u (
        .clk                  (clk),
        .sys_rst              (sys_rst),
        .ce                   (ce),
        .reg_addr             (reg_addr),
        .reg_wdata            (reg_wdata),
        .reg_wr               (reg_wr),
        .reg_rd               (reg_rd),
        .reg_rdata            (reg_rdata),
        .ld_valid             (ld_valid),
        .ld_cspec             (ld_cspec),
        .ld_fault_class       (ld_fault_class),
        .ld_misaligned        (ld_misaligned),
        .ld_fp_target         (ld_fp_target),
        .page_recovery_bit    (page_recovery_bit),
        .ld_done              (ld_done),
        .result_defer         (result_defer),
        .deferred_token_bit   (deferred_token_bit),
        .deferred_float_value (deferred_float_value),
        .fault_deliver        (fault_deliver),
        .fault_cause          (fault_cause),
        .irq                  (irq)
    );

    function automatic logic [8:0] dlv(input logic [CAUSE_W-1:0] c);
        return {5'b00001, c};
    endfunction

    function automatic logic [8:0] dfr(input logic fp);
        return {2'b01, ~fp, fp, 5'h00};
    endfunction

    function automatic logic [DATA_W-1:0] fsr(input logic [CAUSE_W-1:0] c, input logic ed,
                                              input logic sp);
        return {24'h000000, c, 2'b00, ed, sp};
    endfunction

    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp,
                       input string what);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp,
                      input string what);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        chk(reg_rdata, exp, what);
        @(posedge clk);
    endtask

    task automatic ld(input logic c, input int cls, input logic mis, input logic fp,
                      input logic prb, input logic [8:0] exp, input string what);
        ld_valid          <= 1'b1;
        ld_cspec          <= c;
        ld_fault_class    <= CLASS_W'(cls);
        ld_misaligned     <= mis;
        ld_fp_target      <= fp;
        page_recovery_bit <= prb;
        @(posedge clk);
        ld_valid          <= 1'b0;
        #1;
        chk({23'h0, ld_done, result_defer, deferred_token_bit, deferred_float_value,
             fault_deliver, fault_cause}, {23'h0, exp}, what);
        @(posedge clk);
    endtask

    task automatic irq_is(input logic exp);
        #1;
        chk({31'h0, irq}, {31'h0, exp}, "irq level");
        @(posedge clk);
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        $display("ERROR %0t watchdog expired", $time);
        close_out();
    end

    initial begin
        sys_rst = 1'b1;
        ce = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        ld_valid = 1'b0;
        ld_cspec = 1'b0;
        ld_fault_class = CLASS_NONE;
        ld_misaligned = 1'b0;
        ld_fp_target = 1'b0;
        page_recovery_bit = 1'b0;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        // Reset values and refused accesses
        rd(OFF_DCR, {25'h0, DCR_RESET}, "dcr reset");
        rd(OFF_CFG, {31'h0, CFG_RESET}, "cfg reset");
        rd(OFF_IRQ_EN, {30'h0, IRQ_EN_RESET}, "irq enable reset");
        rd(OFF_FSR, 32'h0, "fsr reset");
        wr(8'h40, 32'hFFFF_FFFF);
        rd(8'h40, 32'h0, "unmapped");
        wr(OFF_FSR, 32'h0000_00FF);
        rd(OFF_FSR, 32'h0, "fsr read only");
        rd(OFF_IRQ_CLR, 32'h0, "clear write only");
        // All flags clear: every class reaches the handler
        for (int i = 1; i <= NUM_FLAGS; i++) begin
            ld(1'b1, i, 1'b0, 1'b0, i[0], dlv(CAUSE_W'(i)), "deliver class");
            rd(OFF_FSR, fsr(CAUSE_W'(i), i[0], 1'b1), "fsr spec");
        end
        // All flags set: every class deferred, token by target kind
        wr(OFF_DCR, 32'h0000_007F);
        rd(OFF_DCR, 32'h0000_007F, "dcr seven flags");
        for (int i = 1; i <= NUM_FLAGS; i++) begin
            ld(1'b1, i, 1'b0, i[0], 1'b1, dfr(i[0]), "defer class");
        end
        rd(OFF_FSR, fsr(CAUSE_W'(7), 1'b1, 1'b1), "fsr held on defer");
        ld(1'b0, 6, 1'b0, 1'b0, 1'b1, dlv(CAUSE_W'(6)), "plain load");
        rd(OFF_FSR, fsr(CAUSE_W'(6), 1'b0, 1'b0), "fsr plain");
        // One flag at a time selects its own class only
        for (int i = 1; i <= NUM_FLAGS; i++) begin
            wr(OFF_DCR, DATA_W'(1) << (i - 1));
            ld(1'b1, i, 1'b0, 1'b0, 1'b0, dfr(1'b0), "own flag");
            ld(1'b1, (i % 7) + 1, 1'b0, 1'b0, 1'b0, dlv(CAUSE_W'((i % 7) + 1)), "other");
        end
        // Software deferral request on return
        wr(OFF_DCR, 32'h0);
        @(posedge clk);
        wr(OFF_SAVED, 32'h1);
        rd(OFF_SAVED, 32'h1, "saved set");
        ld(1'b1, 5, 1'b0, 1'b1, 1'b0, dfr(1'b1), "saved defer");
        rd(OFF_SAVED, 32'h0, "saved consumed");
        ld(1'b1, 5, 1'b0, 1'b0, 1'b0, dlv(CAUSE_W'(5)), "refault");
        // Misaligned loads
        ld(1'b1, 0, 1'b1, 1'b0, 1'b0, dlv(CAUSE_UNALIGNED), "unaligned spec");
        ld(1'b0, 0, 1'b1, 1'b0, 1'b0, dlv(CAUSE_UNALIGNED), "unaligned plain");
        ld(1'b0, 3, 1'b1, 1'b0, 1'b0, dlv(CAUSE_W'(3)), "class first");
        wr(OFF_SAVED, 32'h1);
        ld(1'b1, 0, 1'b1, 1'b0, 1'b0, dfr(1'b0), "saved unaligned");
        wr(OFF_CFG, 32'h0);
        ld(1'b0, 0, 1'b1, 1'b0, 1'b0, DONE9, "unaligned off");
        ld(1'b1, 0, 1'b0, 1'b0, 1'b0, DONE9, "clean load");
        // Interrupt status, enable and clear
        wr(OFF_IRQ_CLR, 32'h3);
        rd(OFF_IRQ_STAT, 32'h0, "status cleared");
        ld(1'b1, 2, 1'b0, 1'b0, 1'b0, dlv(CAUSE_W'(2)), "deliver event");
        rd(OFF_IRQ_STAT, 32'h1, "status deliver");
        irq_is(1'b0);
        wr(OFF_IRQ_EN, 32'h1);
        irq_is(1'b1);
        wr(OFF_IRQ_EN, 32'h2);
        irq_is(1'b0);
        wr(OFF_DCR, 32'h0000_0002);
        ld(1'b1, 2, 1'b0, 1'b0, 1'b0, dfr(1'b0), "defer event");
        irq_is(1'b1);
        rd(OFF_IRQ_STAT, 32'h3, "status both");
        wr(OFF_IRQ_CLR, 32'h2);
        irq_is(1'b0);
        rd(OFF_IRQ_STAT, 32'h1, "status after clear");
        // Clock enable low: load not taken
        ce <= 1'b0;
        ld(1'b1, 1, 1'b0, 1'b0, 1'b0, 9'h000, "frozen");
        ce <= 1'b1;
        close_out();
    end
endmodule

`default_nettype wire
